// ===== core/nrc_rx_config.v
// Receiver configuration and status bank with framing control, APB slave
`timescale 1ns/1ps
`include "nrc_map.vh"
module nrc_rx_config #(
  parameter [7:0] GUARD_LIMIT = 8'h20
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  input  wire        sofPulse,
  input  wire        subcarrierLive,
  input  wire        txEnd,
  input  wire        rxStart,
  input  wire        typeBMode,
  input  wire        crcEnable,
  input  wire [1:0]  frameEndSymbolLow,
  input  wire [7:0]  errorReg,
  input  wire        byteValid,
  input  wire [7:0]  byteData,
  input  wire        bytePartial,
  input  wire        frameEnd,
  input  wire        rxError,
  input  wire        rxCollision,
  output reg         fifoWrEn_ff,
  output reg  [7:0]  fifoWrData_ff,
  output reg         fifoReset_ff,
  output reg         rxActive_ff,
  output reg         rxBlank_ff,
  output reg         frameEndTypeB_ff,
  output reg         frameEndCheck_ff,
  output reg         protocolErr_ff,
  output reg         disturbErr_ff,
  output reg         receiveStartIrq_ff,
  output reg         rxIrq_ff,
  output reg  [3:0]  amplitudeThreshold_ff,
  output reg  [3:0]  phaseThreshold_ff
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg  [7:0]  frameStart_ff;
  reg  [7:0]  rxControl_ff;
  reg  [7:0]  rxBlanking_ff;
  reg         subcPrev_ff;
  reg  [7:0]  nxt_frameStart;
  reg         sofLatched_ff;
  reg  [1:0]  frameBytes_ff;
  reg         errPending_ff;
  reg  [6:0]  blankLeft_ff;
  reg  [7:0]  guardCount_ff;
  reg         guardArmed_ff;
  reg  [15:0] halfPeriod;
  reg  [31:0] halfWide;
  wire [31:0] carrierWide;
  wire [7:0]  threshRst;
  reg         rateOk;
  wire        halfTick;
  wire        carrierTick;
  wire        blankTick;
  wire        acceptIn;
  wire        wrAccess;
  wire        setupPhase;
  wire        mapped;
  wire        subcRise;
  wire        suppressHit;
  wire        shortFrame;
  wire        writeOk;

  assign setupPhase = psel && !penable;
  assign wrAccess   = psel && penable && pready_ff && pwrite;
  assign mapped     = paddr == `ADDR_FRAME_START || paddr == `ADDR_RX_CONTROL ||
                      paddr == `ADDR_RX_BLANKING || paddr == `ADDR_RX_THRESH ||
                      paddr == `ADDR_RX_STATUS;

  // ---------------------------------------------------------------
  // Rate decode and time bases
  // ---------------------------------------------------------------
  always @* begin
    rateOk = 1'b1;
    case (rxControl_ff[`RC_RATE_HI:0])
      `RATE_26:  halfWide = `CLK_KHZ / 2 / `BAUD_26;
      `RATE_52:  halfWide = `CLK_KHZ / 2 / `BAUD_52;
      `RATE_106: halfWide = `CLK_KHZ / 2 / `BAUD_106;
      `RATE_212: halfWide = `CLK_KHZ / 2 / `BAUD_212;
      `RATE_424: halfWide = `CLK_KHZ / 2 / `BAUD_424;
      `RATE_847: halfWide = `CLK_KHZ / 2 / `BAUD_847;
      default: begin
        // Reserved codes stop the half-bit base
        halfWide = 32'h0000_0000;
        rateOk   = 1'b0;
      end
    endcase
    // Periods stay far below 16 bits, so the slice loses nothing
    halfPeriod = halfWide[15:0];
  end

  // Rounded to the nearest cycle: truncating would shorten every unit
  assign carrierWide = (`CARRIER_PERIODS * `CLK_KHZ + `CARRIER_KHZ / 2) / `CARRIER_KHZ;

  // Half-bit base follows the data rate code
  // Reserved rate codes hold the half-bit divider idle
  nrc_tick_div u_half_div (
    .clk     (clk),
    .rst     (rst),
    .run     (rateOk),
    .period  (halfPeriod),
    .tick_ff (halfTick)
  );

  nrc_tick_div u_carrier_div (
    .clk     (clk),
    .rst     (rst),
    .run     (1'b1),
    .period  (carrierWide[15:0]),
    .tick_ff (carrierTick)
  );

  assign blankTick = rxBlanking_ff[`BL_UNIT] ? halfTick : carrierTick;

  // ---------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setupPhase;
      pslverr_ff <= setupPhase && !mapped;
      prdata_ff  <= 32'h0000_0000;
      if (setupPhase && !pwrite) begin
        case (paddr)
          `ADDR_FRAME_START: prdata_ff[7:0] <= frameStart_ff;
          `ADDR_RX_CONTROL:  prdata_ff[7:0] <= rxControl_ff;
          `ADDR_RX_BLANKING: prdata_ff[7:0] <= rxBlanking_ff;
          `ADDR_RX_THRESH:   prdata_ff[7:0] <= {amplitudeThreshold_ff, phaseThreshold_ff};
          `ADDR_RX_STATUS: begin
            prdata_ff[`ST_ACTIVE]    <= rxActive_ff;
            prdata_ff[`ST_BLANK]     <= rxBlank_ff;
            prdata_ff[`ST_RATE_OK]   <= rateOk;
            prdata_ff[`ST_EOF_CHECK] <= frameEndCheck_ff;
          end
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Writable configuration
  // ---------------------------------------------------------------
  // Both nibbles reset from the one register value
  assign threshRst = `RST_RX_THRESH;

  always @(posedge clk) begin
    if (rst) begin
      rxControl_ff          <= `RST_RX_CONTROL;
      rxBlanking_ff         <= `RST_RX_BLANKING;
      amplitudeThreshold_ff <= threshRst[7:4];
      phaseThreshold_ff     <= threshRst[3:0];
    end else if (wrAccess) begin
      if (paddr == `ADDR_RX_CONTROL)
        rxControl_ff <= pwdata[7:0];
      if (paddr == `ADDR_RX_BLANKING)
        rxBlanking_ff <= pwdata[7:0];
      if (paddr == `ADDR_RX_THRESH) begin
        amplitudeThreshold_ff <= pwdata[7:4];
        phaseThreshold_ff     <= pwdata[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Detection flags
  // ---------------------------------------------------------------
  assign subcRise = subcarrierLive && !subcPrev_ff;
  assign acceptIn = !rxBlank_ff;

  always @* begin
    nxt_frameStart = frameStart_ff;
    if (wrAccess && paddr == `ADDR_FRAME_START) begin
      nxt_frameStart[`FS_SOF_EN]  = pwdata[`FS_SOF_EN];
      nxt_frameStart[`FS_SUBCARRIER_IRQ_ENABLE] = pwdata[`FS_SUBCARRIER_IRQ_ENABLE];
      // Zero clears a sticky flag, one keeps it
      if (!pwdata[`FS_SOF_SEEN])
        nxt_frameStart[`FS_SOF_SEEN] = 1'b0;
      if (!pwdata[`FS_SUBC_SEEN])
        nxt_frameStart[`FS_SUBC_SEEN] = 1'b0;
    end
    // Detection wins over a clear in the same cycle
    if (sofPulse && acceptIn)
      nxt_frameStart[`FS_SOF_SEEN] = 1'b1;
    if (subcarrierLive && acceptIn)
      nxt_frameStart[`FS_SUBC_SEEN] = 1'b1;
    nxt_frameStart[`FS_SUBC_LIVE] = subcarrierLive;
    nxt_frameStart[7:6] = 2'h0;
    nxt_frameStart[3]   = 1'b0;
  end

  always @(posedge clk) begin
    if (rst) begin
      frameStart_ff      <= `RST_FRAME_START;
      subcPrev_ff        <= 1'b0;
      receiveStartIrq_ff <= 1'b0;
    end else begin
      frameStart_ff      <= nxt_frameStart;
      subcPrev_ff        <= subcarrierLive;
      receiveStartIrq_ff <= acceptIn &&
        ((sofPulse && frameStart_ff[`FS_SOF_EN]) ||
         (subcRise && frameStart_ff[`FS_SUBCARRIER_IRQ_ENABLE]));
    end
  end

  // ---------------------------------------------------------------
  // Post-transmit blanking
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      blankLeft_ff <= 7'h00;
      rxBlank_ff   <= 1'b0;
    end else if (txEnd) begin
      blankLeft_ff <= rxBlanking_ff[`BL_COUNT_HI:0];
      rxBlank_ff   <= rxBlanking_ff[`BL_COUNT_HI:0] != 7'h00;
    end else if (rxBlank_ff && blankTick) begin
      blankLeft_ff <= blankLeft_ff - 7'h01;
      rxBlank_ff   <= blankLeft_ff != 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // Frame end selection
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      frameEndTypeB_ff <= 1'b0;
      frameEndCheck_ff <= 1'b0;
    end else begin
      frameEndTypeB_ff <= rxControl_ff[`RC_EOF_TYPE];
      frameEndCheck_ff <= rxControl_ff[`RC_EOF_TYPE] ||
                          frameEndSymbolLow != 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // Receive framing: FIFO writes, suppression, guard time
  // ---------------------------------------------------------------
  // Complete bytes always pass; a partial one needs allow or no CRC
  assign writeOk = byteValid && rxActive_ff && acceptIn &&
                   (!bytePartial || !crcEnable || rxControl_ff[`RC_ALLOW]);
  assign suppressHit = rxControl_ff[`RC_SUPPRESS] && rxActive_ff &&
                       (rxError || rxCollision) &&
                       frameBytes_ff < `SUPPRESS_BYTES;
  assign shortFrame = rxControl_ff[`RC_SUPPRESS] && sofLatched_ff &&
                      frameBytes_ff < `SUPPRESS_BYTES;

  always @(posedge clk) begin
    if (rst) begin
      rxActive_ff   <= 1'b0;
      fifoWrEn_ff   <= 1'b0;
      fifoWrData_ff <= 8'h00;
      fifoReset_ff  <= 1'b0;
      frameBytes_ff <= 2'h0;
      sofLatched_ff <= 1'b0;
      errPending_ff <= 1'b0;
      disturbErr_ff <= 1'b0;
      rxIrq_ff      <= 1'b0;
    end else begin
      fifoWrEn_ff   <= 1'b0;
      fifoReset_ff  <= 1'b0;
      disturbErr_ff <= 1'b0;
      rxIrq_ff      <= 1'b0;
      if (rxStart)
        rxActive_ff <= 1'b1;
      if (sofPulse && acceptIn && rxActive_ff)
        sofLatched_ff <= 1'b1;
      if (suppressHit) begin
        // Early bytes are taken as noise and dropped
        fifoReset_ff  <= 1'b1;
        frameBytes_ff <= 2'h0;
      end else if (writeOk) begin
        fifoWrEn_ff   <= 1'b1;
        fifoWrData_ff <= byteData;
        if (frameBytes_ff != `SUPPRESS_BYTES)
          frameBytes_ff <= frameBytes_ff + 2'h1;
      end else if (errPending_ff) begin
        // Error byte waits for a free write slot
        fifoWrEn_ff   <= 1'b1;
        fifoWrData_ff <= errorReg;
        errPending_ff <= 1'b0;
      end
      if (frameEnd && rxActive_ff) begin
        frameBytes_ff <= 2'h0;
        sofLatched_ff <= 1'b0;
        if (shortFrame) begin
          disturbErr_ff <= 1'b1;
          fifoReset_ff  <= 1'b1;
        end else begin
          rxIrq_ff <= 1'b1;
        end
        if (rxControl_ff[`RC_MULTI])
          errPending_ff <= 1'b1;
        else
          rxActive_ff <= 1'b0;
      end
    end
  end

  // Gap between bytes counted in half bits, Type B only
  always @(posedge clk) begin
    if (rst) begin
      guardCount_ff  <= 8'h00;
      guardArmed_ff  <= 1'b0;
      protocolErr_ff <= 1'b0;
    end else begin
      protocolErr_ff <= 1'b0;
      if (!rxActive_ff || !typeBMode || !rxControl_ff[`RC_GUARD] || frameEnd) begin
        guardCount_ff <= 8'h00;
        guardArmed_ff <= 1'b0;
      end else if (byteValid) begin
        guardCount_ff <= 8'h00;
        guardArmed_ff <= 1'b1;
      end else if (guardArmed_ff && halfTick) begin
        if (guardCount_ff == GUARD_LIMIT) begin
          // Flag once per gap, then stop counting
          protocolErr_ff <= 1'b1;
          guardArmed_ff  <= 1'b0;
        end else begin
          guardCount_ff <= guardCount_ff + 8'h01;
        end
      end
    end
  end

endmodule // nrc_rx_config

// ===== common/nrc_map.vh
// Address map, field positions, reset values and timing constants of the receiver config bank
`ifndef NRC_MAP_VH
`define NRC_MAP_VH

// ---------------------------------------------------------------
// Register indices and byte addresses (index times four)
// ---------------------------------------------------------------
`define IDX_FRAME_START  8'h34
`define IDX_RX_CONTROL   8'h35
`define IDX_RX_BLANKING  8'h36
`define IDX_RX_THRESHOLD 8'h37
`define IDX_RX_STATUS    8'h40
`define ADDR_FRAME_START ({2'h0, `IDX_FRAME_START, 2'h0})
`define ADDR_RX_CONTROL  ({2'h0, `IDX_RX_CONTROL, 2'h0})
`define ADDR_RX_BLANKING ({2'h0, `IDX_RX_BLANKING, 2'h0})
`define ADDR_RX_THRESH   ({2'h0, `IDX_RX_THRESHOLD, 2'h0})
`define ADDR_RX_STATUS   ({2'h0, `IDX_RX_STATUS, 2'h0})

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FS_SOF_EN     5
`define FS_SOF_SEEN   4
`define FS_SUBCARRIER_IRQ_ENABLE    2
`define FS_SUBC_SEEN  1
`define FS_SUBC_LIVE  0
`define RC_ALLOW      7
`define RC_MULTI      6
`define RC_EOF_TYPE   5
`define RC_GUARD      4
`define RC_SUPPRESS   3
`define RC_RATE_HI    2
`define BL_UNIT       7
`define BL_COUNT_HI   6
`define ST_ACTIVE     0
`define ST_BLANK      1
`define ST_RATE_OK    2
`define ST_EOF_CHECK  3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_FRAME_START 8'h00
`define RST_RX_CONTROL  8'h00
`define RST_RX_BLANKING 8'h00
`define RST_RX_THRESH   8'h00

// ---------------------------------------------------------------
// Rates and timing
// ---------------------------------------------------------------
`define CLK_KHZ         100000
`define CARRIER_KHZ     13560
`define CARRIER_PERIODS 16
`define BAUD_26   26
`define BAUD_52   52
`define BAUD_106  106
`define BAUD_212  212
`define BAUD_424  424
`define BAUD_847  847
`define RATE_26   3'h2
`define RATE_52   3'h3
`define RATE_106  3'h4
`define RATE_212  3'h5
`define RATE_424  3'h6
`define RATE_847  3'h7
`define SUPPRESS_BYTES 2'h3

`endif

// ===== core/nrc_tick_div.v
// Programmable divider giving a one-cycle tick every period cycles
`timescale 1ns/1ps
module nrc_tick_div (
  input  wire        clk,
  input  wire        rst,
  input  wire        run,
  input  wire [15:0] period,
  output reg         tick_ff
);

  reg [15:0] count_ff;

  // A zero period means no valid rate: stay silent
  always @(posedge clk) begin
    if (rst || !run || period == 16'h0000) begin
      count_ff <= 16'h0000;
      tick_ff  <= 1'b0;
    end else if (count_ff >= period - 16'h0001) begin
      count_ff <= 16'h0000;
      tick_ff  <= 1'b1;
    end else begin
      count_ff <= count_ff + 16'h0001;
      tick_ff  <= 1'b0;
    end
  end

endmodule // nrc_tick_div

// ===== dv/nrc_rx_config_properties.sv
// Port-level assertions for the receiver config bank
`timescale 1ns/1ps
module nrc_rx_config_properties (
  input logic       clk,
  input logic       rst,
  input logic       psel,
  input logic       penable,
  input logic       pready_ff,
  input logic       sofPulse,
  input logic       subcarrierLive,
  input logic       txEnd,
  input logic       rxStart,
  input logic       byteValid,
  input logic       bytePartial,
  input logic [7:0] byteData,
  input logic       frameEnd,
  input logic       fifoWrEn_ff,
  input logic [7:0] fifoWrData_ff,
  input logic       fifoReset_ff,
  input logic       rxActive_ff,
  input logic       rxBlank_ff,
  input logic       disturbErr_ff,
  input logic       receiveStartIrq_ff,
  input logic       rxIrq_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_irq_cause;
    receiveStartIrq_ff |-> $past(sofPulse) || ($past(subcarrierLive) && !$past(subcarrierLive, 2));
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("start irq without detection");
  property p_wr_data;
    fifoWrEn_ff && $past(byteValid && rxActive_ff && !rxBlank_ff && !bytePartial)
      |-> fifoWrData_ff == $past(byteData);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("fifo data differs from byte");
  property p_blank_ignore;
    rxBlank_ff && sofPulse && !subcarrierLive |=> !receiveStartIrq_ff;
  endproperty
  a_blank_ignore: assert property (p_blank_ignore)
    else $error("detection taken while blanked");
  property p_blank_start;
    $rose(rxBlank_ff) |-> $past(txEnd);
  endproperty
  a_blank_start: assert property (p_blank_start)
    else $error("blanking without transmit end");
  property p_rx_irq;
    rxIrq_ff |-> $past(frameEnd) && !disturbErr_ff;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("rx irq without clean frame end");
  property p_dist;
    disturbErr_ff |-> fifoReset_ff && $past(frameEnd);
  endproperty
  a_dist: assert property (p_dist)
    else $error("disturbance without fifo reset");
  property p_active;
    rxStart |=> rxActive_ff;
  endproperty
  a_active: assert property (p_active)
    else $error("receiver not active after start");
  property p_ready;
    psel && !penable |=> pready_ff ##1 !pready_ff;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not one cycle in access");
endmodule // nrc_rx_config_properties

// ===== dv/nrc_rf_model.sv
// Behavioural RF demodulator feeding frames to the config bank
`timescale 1ns/1ps
module nrc_rf_model (
  output logic       sofPulse,
  output logic       subcarrierLive,
  output logic       byteValid,
  output logic       bytePartial,
  output logic [7:0] byteData,
  output logic       frameEnd,
  output logic       rxError,
  output logic       rxCollision,
  input  logic       clk
);
  initial begin
    {sofPulse, subcarrierLive, byteValid, bytePartial, frameEnd, rxError, rxCollision} = '0;
    byteData = 8'ha5;
  end
  task automatic pulse_sof();
    @(posedge clk) sofPulse <= 1'b1;
    @(posedge clk) sofPulse <= 1'b0;
  endtask
  task automatic set_subc(input logic v);
    @(posedge clk) subcarrierLive <= v;
  endtask
  // Data line inverted between bytes so a stale value never looks valid
  task automatic send_byte(input logic [7:0] d, input logic part, input logic err, input logic col);
    @(posedge clk);
    byteValid <= 1'b1;
    byteData <= d;
    bytePartial <= part;
    rxError <= err && !col;
    rxCollision <= err && col;
    @(posedge clk);
    {byteValid, bytePartial, rxError, rxCollision} <= '0;
    byteData <= ~d;
  endtask
  task automatic send_frame(input int n, input logic [7:0] b, input logic pl, input int ea, input logic col);
    pulse_sof();
    for (int i = 0; i < n; i++) send_byte(b + i[7:0], pl && i == n - 1, i == ea, col);
    @(posedge clk) frameEnd <= 1'b1;
    @(posedge clk) frameEnd <= 1'b0;
  endtask
endmodule // nrc_rf_model

// ===== dv/nrc_rx_config_tb.sv
// Self-checking bench for the receiver config bank
`timescale 1ns/1ps
`include "nrc_map.vh"
module nrc_rx_config_tb;
  localparam logic [11:0] FS = `ADDR_FRAME_START, RC = `ADDR_RX_CONTROL, BL = `ADDR_RX_BLANKING;
  localparam logic [11:0] TH = `ADDR_RX_THRESH, ST = `ADDR_RX_STATUS;
  logic        clk, rst, psel, penable, pwrite, txEnd, rxStart, typeBMode, crcEnable, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [1:0]  frameEndSymbolLow;
  logic [7:0]  errorReg, lastWr;
  wire  [31:0] prdata_ff;
  wire  [7:0]  byteData, fifoWrData_ff;
  wire  [3:0]  amplitudeThreshold_ff, phaseThreshold_ff;
  wire         pready_ff, pslverr_ff, sofPulse, subcarrierLive, byteValid, bytePartial, frameEnd, rxError;
  wire         rxCollision, fifoWrEn_ff, fifoReset_ff, rxActive_ff, rxBlank_ff, frameEndTypeB_ff;
  wire         frameEndCheck_ff, protocolErr_ff, disturbErr_ff, receiveStartIrq_ff, rxIrq_ff;
  int          miscompares = 0, num_checks = 0, nWr = 0, nIrq = 0, nRxIrq = 0, nDist = 0, nRst = 0;
  int          nPerr = 0, nBlank = 0;

  nrc_rx_config #(.GUARD_LIMIT(8'h04)) uut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata_ff,
    .pready_ff, .pslverr_ff, .sofPulse, .subcarrierLive, .txEnd, .rxStart, .typeBMode, .crcEnable,
    .frameEndSymbolLow, .errorReg, .byteValid, .byteData, .bytePartial, .frameEnd, .rxError, .rxCollision,
    .fifoWrEn_ff, .fifoWrData_ff, .fifoReset_ff, .rxActive_ff, .rxBlank_ff, .frameEndTypeB_ff,
    .frameEndCheck_ff, .protocolErr_ff, .disturbErr_ff, .receiveStartIrq_ff, .rxIrq_ff,
    .amplitudeThreshold_ff, .phaseThreshold_ff);
  nrc_rf_model rf (.clk, .sofPulse, .subcarrierLive, .byteValid, .bytePartial, .byteData, .frameEnd,
    .rxError, .rxCollision);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulses counted at every edge so none is missed between bus cycles
  always @(posedge clk) begin
    nWr <= nWr + fifoWrEn_ff;
    nIrq <= nIrq + receiveStartIrq_ff;
    nRxIrq <= nRxIrq + rxIrq_ff;
    nDist <= nDist + disturbErr_ff;
    nRst <= nRst + fifoReset_ff;
    nPerr <= nPerr + protocolErr_ff;
    nBlank <= nBlank + rxBlank_ff;
    if (fifoWrEn_ff === 1'b1) lastWr <= fifoWrData_ff;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready_ff !== 1'b1);
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic clr();
    @(negedge clk);
    {nWr, nIrq, nRxIrq, nDist, nRst, nPerr, nBlank} = '0;
  endtask
  task automatic kick(input logic tx);
    @(posedge clk);
    txEnd <= tx;
    rxStart <= !tx;
    @(posedge clk);
    txEnd <= 1'b0;
    rxStart <= 1'b0;
  endtask
  task automatic run(input logic [7:0] rc, input int n, input logic pl, input int ea, input logic col);
    clr();
    apb(1'b1, RC, {24'h0, rc});
    kick(1'b0);
    rf.send_frame(n, 8'h10, pl, ea, col);
    repeat (4) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rdchk(FS, {24'h0, `RST_FRAME_START});
    rdchk(RC, {24'h0, `RST_RX_CONTROL});
    rdchk(BL, {24'h0, `RST_RX_BLANKING});
    rdchk(TH, {24'h0, `RST_RX_THRESH});
    apb(1'b1, TH, 32'h0000_a5a5);
    rdchk(TH, 32'ha5);
    chk("amplitude", 32'ha, {28'h0, amplitudeThreshold_ff});
    chk("phase", 32'h5, {28'h0, phaseThreshold_ff});
    apb(1'b0, 12'h0e0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("regs done");
  endtask
  task automatic t_flags();
    clr();
    rf.pulse_sof();
    rdchk(FS, 32'h10);
    chk("irq masked", 32'h0, nIrq);
    apb(1'b1, FS, 32'h34);
    rdchk(FS, 32'h34);
    apb(1'b1, FS, 32'h24);
    rdchk(FS, 32'h24);
    rf.pulse_sof();
    rdchk(FS, 32'h34);
    chk("sof irq", 32'h1, nIrq);
    rf.set_subc(1'b1);
    rdchk(FS, 32'h37);
    chk("subc irq", 32'h2, nIrq);
    rf.set_subc(1'b0);
    rdchk(FS, 32'h36);
    apb(1'b1, FS, 32'h24);
    rdchk(FS, 32'h24);
    $display("flags done");
  endtask
  task automatic t_rx();
    for (int m = 0; m < 2; m++) begin
      run(m ? 8'h47 : 8'h07, 3, 1'b0, 9, 1'b0);
      chk("writes", 32'd3 + m, nWr);
      chk("last write", m ? {24'h0, errorReg} : 32'h12, {24'h0, lastWr});
      chk("rx irq", 32'h1, nRxIrq);
      chk("active", m, {31'h0, rxActive_ff});
    end
    crcEnable <= 1'b1;
    for (int a = 0; a < 2; a++) begin
      run(a ? 8'h87 : 8'h07, 3, 1'b1, 9, 1'b0);
      chk("partial kept", 32'd2 + a, nWr);
    end
    crcEnable <= 1'b0;
    $display("receive done");
  endtask
  task automatic t_suppress();
    run(8'h0f, 2, 1'b0, 9, 1'b0);
    chk("short frame", 32'h1, nDist);
    chk("no rx irq", 32'h0, nRxIrq);
    for (int c = 0; c < 2; c++) begin
      run(8'h0f, 5, 1'b0, 1, c[0]);
      chk("early error reset", 32'h1, nRst);
      chk("writes after reset", 32'h4, nWr);
      chk("data after three", 32'h14, {24'h0, lastWr});
    end
    $display("suppress done");
  endtask
  task automatic t_eof();
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, RC, c);
      rdchk(ST, {29'h0, c > 1, 2'h0});
      chk("rate ok", c > 1, {31'h0, rd[`ST_RATE_OK]});
    end
    for (int t = 0; t < 8; t++) begin
      frameEndSymbolLow <= t[1:0];
      apb(1'b1, RC, t[2] ? 32'h27 : 32'h07);
      repeat (2) @(posedge clk);
      chk("type b", t[2], {31'h0, frameEndTypeB_ff});
      chk("eof check", t[2] || t[1:0] != 2'h0, {31'h0, frameEndCheck_ff});
    end
    $display("eof done");
  endtask
  task automatic t_guard();
    typeBMode <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      clr();
      apb(1'b1, RC, g ? 32'h17 : 32'h07);
      kick(1'b0);
      rf.send_byte(8'h55, 1'b0, 1'b0, 1'b0);
      repeat (600) @(posedge clk);
      chk("guard err", g, nPerr != 0);
    end
    typeBMode <= 1'b0;
    $display("guard done");
  endtask
  task automatic t_blank();
    int cnt[3] = '{2, 3, 0};
    int tk[3] = '{118, 59, 118};
    apb(1'b1, RC, 32'h07);
    apb(1'b1, FS, 32'h20);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, BL, {24'h0, k[0], 7'(cnt[k])});
      clr();
      kick(1'b1);
      rf.pulse_sof();
      repeat (400) @(posedge clk);
      chk("blank len", 1, nBlank > (cnt[k] - 1) * tk[k] && nBlank <= cnt[k] * tk[k] + 1);
      chk("irq in blank", cnt[k] == 0, nIrq);
    end
    $display("blank done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {psel, penable, pwrite, txEnd, rxStart, typeBMode, crcEnable} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    frameEndSymbolLow = 2'h0;
    errorReg = 8'h3c;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_flags();
    t_rx();
    t_suppress();
    t_eof();
    t_guard();
    t_blank();
    tally_and_finish();
  end
endmodule // nrc_rx_config_tb

bind nrc_rx_config nrc_rx_config_properties chk_i (.clk, .rst, .psel, .penable, .pready_ff, .sofPulse,
  .subcarrierLive, .txEnd, .rxStart, .byteValid, .bytePartial, .byteData, .frameEnd, .fifoWrEn_ff,
  .fifoWrData_ff, .fifoReset_ff, .rxActive_ff, .rxBlank_ff, .disturbErr_ff, .receiveStartIrq_ff, .rxIrq_ff);
